// ---- rtl/fwg_host.v ----
`timescale 1ns/100ps
`default_nettype none
`include "fwg_consts.vh"

module fwg_host #(
  parameter AW = 19,
  parameter DW = 8,
  parameter WP_CYC = `FWG_CYC(`FWG_T_WP_NS),
  parameter WPH_CYC = `FWG_CYC(`FWG_T_WPH_NS),
  parameter ACC_CYC = `FWG_CYC(`FWG_T_ACC_NS),
  parameter PROT_CYC = `FWG_CYC(`FWG_T_WPP1_NS),
  parameter UNPROT_CYC = `FWG_CYC(`FWG_T_WPP2_NS)
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // User request
  input wire req_valid,
  output wire req_ready,
  input wire [2:0] req_op,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  input wire temp_unprotect,
  // User answer
  output reg done_r,
  output reg [DW-1:0] rdata_r,
  output reg rejected_r,
  output reg protected_r,
  // Flash pins
  output reg [AW-1:0] flash_addr_r,
  output reg flash_ce_n_r,
  output reg flash_oe_n_r,
  output reg flash_we_n_r,
  output reg flash_rst_n_r,
  output reg hv_addr_r,
  output reg hv_oe_r,
  output reg hv_rst_r,
  input wire [DW-1:0] flash_dq_in,
  output reg [DW-1:0] flash_dq_out_r,
  output reg flash_dq_oe_n_r
);

  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_PULSE = 3'h2;
  localparam ST_RECOVER = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_NEXT = 3'h5;

  reg [2:0] state_r;
  reg [2:0] op_r;
  reg [`FWG_CNT_W-1:0] cnt_r;
  reg [1:0] phase_r;
  reg window_before_r;
  reg [AW-1:0] addr_hold_r;
  wire [DW-1:0] dq_sync;

  // Pins from the flash are asynchronous
  fwg_sync2 #(.W(DW)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(flash_dq_in),
    .q(dq_sync)
  );

  assign req_ready = (state_r == ST_IDLE);

  // Pulse width for the current op; high-voltage ops need longer strobes
  function [`FWG_CNT_W-1:0] pulse_len;
    input [2:0] op;
    begin
      case (op)
        `FWG_OP_PROTECT: pulse_len = PROT_CYC[`FWG_CNT_W-1:0];
        `FWG_OP_UNPROTECT: pulse_len = UNPROT_CYC[`FWG_CNT_W-1:0];
        default: pulse_len = WP_CYC[`FWG_CNT_W-1:0];
      endcase
    end
  endfunction

  // Op needs a write strobe
  function is_write;
    input [2:0] op;
    begin
      is_write = (op == `FWG_OP_WRITE) || (op == `FWG_OP_PROTECT) ||
                 (op == `FWG_OP_UNPROTECT);
    end
  endfunction

  // ----------------------------------------
  // Sequencer driving the flash strobes
  // ----------------------------------------
  // All strobes idle high so no stray write can start [R9]
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r <= 3'h0;
      cnt_r <= {`FWG_CNT_W{1'b0}};
      phase_r <= 2'h0;
      window_before_r <= 1'b0;
      addr_hold_r <= {AW{1'b0}};
      done_r <= 1'b0;
      rdata_r <= {DW{1'b0}};
      rejected_r <= 1'b0;
      protected_r <= 1'b0;
      flash_addr_r <= {AW{1'b0}};
      flash_ce_n_r <= 1'b1;
      flash_oe_n_r <= 1'b1;
      flash_we_n_r <= 1'b1;
      flash_rst_n_r <= 1'b1;
      hv_addr_r <= 1'b0;
      hv_oe_r <= 1'b0;
      hv_rst_r <= 1'b0;
      flash_dq_out_r <= {DW{1'b0}};
      flash_dq_oe_n_r <= 1'b1;
    end else begin
      done_r <= 1'b0;
      // Reset-pin high voltage follows temp_unprotect only while idle and is held through a transfer [R11]
      if (state_r == ST_IDLE) begin
        hv_rst_r <= temp_unprotect;
      end
      case (state_r)
        ST_IDLE: begin
          if (req_valid) begin
            op_r <= req_op;
            // Keep the address: the user may change req_addr once taken
            addr_hold_r <= req_addr;
            flash_addr_r <= req_addr;
            flash_dq_out_r <= req_wdata;
            phase_r <= 2'h0;
            // High voltage on select address for protect, verify, unprotect [R13] [R14] [R17]
            hv_addr_r <= (req_op == `FWG_OP_PROTECT) || (req_op == `FWG_OP_VERIFY) ||
                         (req_op == `FWG_OP_UNPROTECT);
            hv_oe_r <= (req_op == `FWG_OP_PROTECT) || (req_op == `FWG_OP_UNPROTECT);
            // Whole-chip unprotect; callers protect every sector before it [R18]
            if (req_op == `FWG_OP_UNPROTECT) begin
              flash_addr_r[`FWG_PROTECT_OP_BIT] <= 1'b1; // [R17]
            end
            if (req_op == `FWG_OP_VERIFY) begin
              flash_addr_r[`FWG_ID_SPACE_BIT] <= 1'b1; // [R14]
              flash_addr_r[`FWG_ID_LOW_BIT] <= 1'b0;
              flash_addr_r[`FWG_PROTECT_OP_BIT] <= 1'b0;
            end
            if (req_op == `FWG_OP_ADD_SECTOR) begin
              flash_addr_r <= {AW{1'b0}}; // Status read precedes the command [R5]
            end
            cnt_r <= 16'h0001;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (op_r == `FWG_OP_ADD_SECTOR && phase_r != 2'h1) begin
            flash_ce_n_r <= 1'b0;
            flash_oe_n_r <= 1'b0;
            cnt_r <= ACC_CYC[`FWG_CNT_W-1:0];
            state_r <= ST_READ;
          end else if (is_write(op_r) || op_r == `FWG_OP_ADD_SECTOR) begin
            // Output enable high before chip select and strobe go low [R10]
            flash_oe_n_r <= 1'b1;
            flash_ce_n_r <= 1'b0;
            flash_we_n_r <= 1'b0;
            flash_dq_oe_n_r <= 1'b0;
            // Strobe held well past the glitch filter [R8]
            cnt_r <= pulse_len(op_r);
            state_r <= ST_PULSE;
          end else begin
            flash_ce_n_r <= 1'b0;
            flash_oe_n_r <= 1'b0;
            cnt_r <= ACC_CYC[`FWG_CNT_W-1:0];
            state_r <= ST_READ;
          end
        end
        ST_PULSE: begin
          if (cnt_r <= 16'h0001) begin
            // Rising edge ends protect/unprotect programming [R13] [R17]
            flash_we_n_r <= 1'b1;
            cnt_r <= WPH_CYC[`FWG_CNT_W-1:0];
            state_r <= ST_RECOVER;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_RECOVER: begin
          flash_ce_n_r <= 1'b1;
          flash_dq_oe_n_r <= 1'b1;
          if (cnt_r <= 16'h0001) begin
            if (op_r == `FWG_OP_ADD_SECTOR) begin
              phase_r <= 2'h2;
              flash_addr_r <= {AW{1'b0}};
              cnt_r <= 16'h0001;
              state_r <= ST_SETUP;
            end else begin
              state_r <= ST_NEXT;
            end
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_READ: begin
          if (cnt_r <= 16'h0001) begin
            flash_ce_n_r <= 1'b1;
            flash_oe_n_r <= 1'b1;
            if (op_r == `FWG_OP_ADD_SECTOR && phase_r == 2'h0) begin
              // Check window before adding a sector [R5]
              window_before_r <= dq_sync[`FWG_ERASE_WINDOW_BIT];
              phase_r <= 2'h1;
              flash_addr_r <= addr_hold_r;
              cnt_r <= 16'h0001;
              state_r <= ST_SETUP;
            end else begin
              rdata_r <= dq_sync;
              if (op_r == `FWG_OP_ADD_SECTOR) begin
                // High before or after the command: possibly not accepted [R5]
                rejected_r <= dq_sync[`FWG_ERASE_WINDOW_BIT] | window_before_r;
              end
              if (op_r == `FWG_OP_VERIFY) begin
                protected_r <= dq_sync[`FWG_PROTECT_STATUS_BIT]; // [R14]
              end
              state_r <= ST_NEXT;
            end
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_NEXT: begin
          hv_addr_r <= 1'b0;
          hv_oe_r <= 1'b0;
          done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- rtl/fwg_consts.vh ----
// Overview of operation
// [R1] After first sector-erase sequence the device keeps erase-window bit low until time-out.
// [R2] Polling and toggle status are valid right after the first sector-erase sequence.
// [R3] Erase-window bit high: further commands ignored until erase finishes.
// [R4] Erase-window bit low: more sector-erase commands are accepted and added; the flash model ignores them.
// [R5] Host reads erase-window bit before and after each added sector; high after means rejected.
// [R6] Device powers up in array read mode with nothing pending.
// [R7] Array changes only after a complete valid command sequence.
// [R8] Strobe glitches under about 5 ns do not start a write.
// [R9] Write inhibited by output enable low, chip select high or write strobe high.
// [R10] Write needs chip select and write strobe low with output enable high.
// [R11] High voltage on reset pin temporarily unprotects sectors; removal restores protection.
// [R12] Protected sectors refuse program and erase.
// [R13] Sector protect: high voltage on select address and output enable, pulse write strobe.
// [R14] Protect verify: high voltage on select address, read; bit 0 is 1 when protected.
// [R15] Identification space with address bit 1 low returns identification codes.
// [R16] After identification-read command, address bit 1 high reads 1 on bit 0 if protected.
// [R17] Chip unprotect: high voltage on output enable and select address, bit 6 high, pulse.
// [R18] Protect every sector before running whole-chip unprotect.
// [R19] After identification-read command, unprotected sector reads 00H.
`ifndef FWG_CONSTS_VH
`define FWG_CONSTS_VH

// ----------------------------------------
// Operation codes on the user port
// ----------------------------------------
`define FWG_OP_READ 3'h0
`define FWG_OP_WRITE 3'h1
`define FWG_OP_ADD_SECTOR 3'h2
`define FWG_OP_PROTECT 3'h3
`define FWG_OP_VERIFY 3'h4
`define FWG_OP_UNPROTECT 3'h5

// ----------------------------------------
// Status bit positions and address bits
// ----------------------------------------
`define FWG_ERASE_WINDOW_BIT 3
`define FWG_PROTECT_STATUS_BIT 0
`define FWG_ID_SPACE_BIT 1
`define FWG_ID_LOW_BIT 0
`define FWG_PROTECT_OP_BIT 6

// ----------------------------------------
// Timing (ns) and derived cycles at 10 ns
// ----------------------------------------
`define FWG_CLK_NS 10
`define FWG_T_WP_NS 35
`define FWG_T_WPH_NS 30
`define FWG_T_ACC_NS 70
`define FWG_T_WPP1_NS 100
`define FWG_T_WPP2_NS 100
`define FWG_CYC(ns) (((ns) + `FWG_CLK_NS - 1) / `FWG_CLK_NS)
`define FWG_CNT_W 16

`endif

// ---- rtl/fwg_sync2.v ----
`timescale 1ns/100ps
`default_nettype none

module fwg_sync2 #(
  parameter W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  // First stage feeds only the second stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- test/fwg_host_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// Checks the strobe and high-voltage sequencing at the flash pins
module fwg_host_chk (
  // Clock, reset and user side
  input wire mclk,
  input wire rst_n,
  input wire req_ready,
  input wire temp_unprotect,
  // Flash pins
  input wire [18:0] flash_addr_r,
  input wire flash_ce_n_r,
  input wire flash_oe_n_r,
  input wire flash_we_n_r,
  input wire hv_addr_r,
  input wire hv_oe_r,
  input wire hv_rst_r,
  input wire flash_dq_oe_n_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_wr_combo;
    !flash_we_n_r && !hv_oe_r |-> !flash_ce_n_r && flash_oe_n_r;
  endproperty
  a_wr_combo: assert property (p_wr_combo) else $error("write strobe outside a select");
  // Driving data while the flash drives it would fight on the bus
  property p_no_clash;
    !flash_dq_oe_n_r |-> flash_oe_n_r || hv_oe_r;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("data driven with output enabled");
  property p_wp_min;
    $fell(flash_we_n_r) |-> !flash_we_n_r [*4];
  endproperty
  a_wp_min: assert property (p_wp_min) else $error("write pulse too short");
  property p_prot_pulse;
    $fell(flash_we_n_r) && hv_oe_r |-> (hv_oe_r && hv_addr_r && !flash_we_n_r) [*8];
  endproperty
  a_prot_pulse: assert property (p_prot_pulse) else $error("protect pulse broken");
  property p_hv_hold;
    $rose(flash_we_n_r) && $past(hv_oe_r) |-> hv_oe_r && hv_addr_r;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("high voltage left early");
  property p_unprot_ce;
    !flash_we_n_r && hv_oe_r && flash_addr_r[6] |-> !flash_ce_n_r;
  endproperty
  a_unprot_ce: assert property (p_unprot_ce) else $error("unprotect without select");
  property p_verify;
    hv_addr_r && !hv_oe_r && !flash_oe_n_r |->
      flash_we_n_r && !flash_ce_n_r && flash_addr_r[1] && !flash_addr_r[0] && !flash_addr_r[6];
  endproperty
  a_verify: assert property (p_verify) else $error("verify read set up wrongly");
  property p_temp;
    temp_unprotect && req_ready |-> ##[1:2] hv_rst_r;
  endproperty
  a_temp: assert property (p_temp) else $error("reset pin not raised");
endmodule
bind fwg_host fwg_host_chk fwg_host_chk_inst (.mclk(mclk), .rst_n(rst_n),
  .req_ready(req_ready), .temp_unprotect(temp_unprotect), .flash_addr_r(flash_addr_r),
  .flash_ce_n_r(flash_ce_n_r), .flash_oe_n_r(flash_oe_n_r), .flash_we_n_r(flash_we_n_r),
  .hv_addr_r(hv_addr_r), .hv_oe_r(hv_oe_r), .hv_rst_r(hv_rst_r),
  .flash_dq_oe_n_r(flash_dq_oe_n_r));
`default_nettype wire

// ---- test/fwg_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Behavioural flash: tiny array, sector protect bits, erase window
module fwg_flash_model #(
  parameter WIN_NS = 800,
  parameter ERASE_NS = 1500,
  parameter [7:0] ID_CODE = 8'h5C // Arbitrary value
) (
  // Pins from the controller
  input wire [18:0] addr,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [7:0] din,
  input wire dq_oe_n,
  input wire hv_addr,
  input wire hv_oe,
  input wire hv_rst,
  // Data towards the controller
  output wire [7:0] dout
);
  reg [7:0] mem [0:15];
  reg [7:0] prot = 8'h00;
  reg [7:0] last = 8'h00;
  reg [1:0] mode = 2'd0; // Array read mode at power-up
  reg closed = 1'b0;
  reg tog = 1'b0;
  realtime t_fall = 0;
  wire [2:0] sec = addr[18:16];
  wire id_rd = hv_addr || (mode == 2'd2);
  wire [7:0] rd = id_rd ? (addr[1] ? {7'h00, prot[sec]} : ID_CODE) :
    (mode == 2'd3) ? {1'b0, tog, 2'b00, closed, 3'b000} : mem[addr[3:0]];
  // Released bus shows the inverse of the last value, not a kind copy
  assign dout = (!ce_n && !oe_n) ? rd : ~last;
  always @* if (!ce_n && !oe_n) last = rd;
  // Toggle once per read; both strobes may fall in the same time step
  wire rd_act = !ce_n && !oe_n;
  always @(posedge rd_act) tog <= ~tog;
  initial for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
  always @(negedge we_n) t_fall = $realtime;
  // Commands land on the strobe's rising edge only
  always @(posedge we_n) begin
    if (hv_oe && hv_addr) begin
      if (!addr[6]) prot[sec] = 1'b1;
      else if (!ce_n) prot = 8'h00;
    end else if (!ce_n && oe_n && !dq_oe_n && $realtime - t_fall >= 5.0) begin
      if (mode == 2'd3) begin
        if (closed) tog = tog; // Ignored while erasing
      end else if (mode == 2'd1) begin
        if (!prot[sec] || hv_rst) mem[addr[3:0]] = din;
        mode = 2'd0;
      end else if (din == 8'hA0) mode = 2'd1;
      else if (din == 8'h90) mode = 2'd2;
      else if (din == 8'hF0) mode = 2'd0;
      else if (din == 8'h30) begin
        mode = 2'd3;
        closed = 1'b0; // Window open: erase-window bit low, further commands still ignored
        closed <= #(WIN_NS) 1'b1;
        mode <= #(WIN_NS + ERASE_NS) 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/flash_write_guard_erase_window_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fwg_consts.vh"
// Bench: controller against the behavioural flash
module flash_write_guard_erase_window_bench;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg req_valid = 1'b0;
  reg [2:0] req_op = 3'h0;
  reg [18:0] req_addr = 19'h00000;
  reg [7:0] req_wdata = 8'h00;
  reg temp_unprotect = 1'b0;
  wire req_ready, done_r, rejected_r, protected_r, ce_n, oe_n, we_n, hva, hvo, hvr, dq_oe_n;
  wire [7:0] rdata_r, dq_in, dq_out;
  wire [18:0] fa;
  wire frst;
  integer err_total = 0;
  integer comparisons = 0;
  reg t;
  always #5 mclk = ~mclk;
  fwg_host fwg_host_inst (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .temp_unprotect(temp_unprotect), .done_r(done_r), .rdata_r(rdata_r),
    .rejected_r(rejected_r), .protected_r(protected_r), .flash_addr_r(fa),
    .flash_ce_n_r(ce_n), .flash_oe_n_r(oe_n), .flash_we_n_r(we_n), .flash_rst_n_r(frst),
    .hv_addr_r(hva), .hv_oe_r(hvo), .hv_rst_r(hvr), .flash_dq_in(dq_in),
    .flash_dq_out_r(dq_out), .flash_dq_oe_n_r(dq_oe_n));
  fwg_flash_model fwg_flash_model_inst (.addr(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .din(dq_out), .dq_oe_n(dq_oe_n), .hv_addr(hva), .hv_oe(hvo), .hv_rst(hvr), .dout(dq_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task conclude;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    begin
      comparisons++;
      if (got !== exp) begin
        $display("unexpected %0s expected %h seen %h", nm, exp, got);
        err_total++;
      end
    end
  endtask
  // One request, then a bounded wait for its completion pulse
  task op(input [2:0] o, input [18:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      while (req_ready !== 1'b1 && n < 500) begin @(posedge mclk); n++; end
      if (n == 500) begin err_total++; conclude(); end
      req_op <= o;
      req_addr <= a;
      req_wdata <= d;
      req_valid <= 1'b1;
      @(posedge mclk);
      req_valid <= 1'b0;
      n = 0;
      while (done_r !== 1'b1 && n < 500) begin @(posedge mclk); n++; end
      if (n == 500) begin err_total++; conclude(); end
    end
  endtask
  task pgm(input [7:0] d);
    begin op(`FWG_OP_WRITE, 19'h3, 8'hA0); op(`FWG_OP_WRITE, 19'h3, d); op(`FWG_OP_READ, 19'h3, 0); end
  endtask
  task s_program;
    begin
      chk("reset pin", 8'h01, {7'h00, frst});
      pgm(8'h5A); chk("array", 8'h5A, rdata_r);
      op(`FWG_OP_WRITE, 19'h4, 8'h5A); op(`FWG_OP_READ, 19'h4, 0);
      chk("partial", 8'hFF, rdata_r);
    end
  endtask
  task s_protect;
    begin
      op(`FWG_OP_PROTECT, 19'h0, 0); op(`FWG_OP_VERIFY, 19'h2, 0);
      chk("verify", 8'h01, {7'h00, protected_r});
      pgm(8'h00); chk("locked", 8'h5A, rdata_r);
      temp_unprotect <= 1'b1;
      pgm(8'h00); chk("temp", 8'h00, rdata_r);
      temp_unprotect <= 1'b0;
      pgm(8'h11); chk("relocked", 8'h00, rdata_r);
    end
  endtask
  task s_id;
    integer s;
    begin
      op(`FWG_OP_WRITE, 0, 8'h90); op(`FWG_OP_READ, 19'h2, 0);
      chk("prot id", 8'h01, rdata_r);
      op(`FWG_OP_READ, 19'h0, 0); chk("id code", 8'h5C, rdata_r);
      op(`FWG_OP_WRITE, 0, 8'hF0);
      for (s = 0; s < 8; s++) op(`FWG_OP_PROTECT, {s[2:0], 16'h0000}, 0);
      op(`FWG_OP_VERIFY, 19'h70002, 0);
      chk("all protected", 8'h01, {7'h00, protected_r});
      op(`FWG_OP_UNPROTECT, 19'h40, 0);
      op(`FWG_OP_VERIFY, 19'h70002, 0);
      chk("all unprotected", 8'h00, {7'h00, protected_r});
      op(`FWG_OP_WRITE, 0, 8'h90); op(`FWG_OP_READ, 19'h2, 0);
      chk("unprot id", 8'h00, rdata_r);
      op(`FWG_OP_WRITE, 0, 8'hF0);
    end
  endtask
  task s_erase;
    begin
      op(`FWG_OP_WRITE, 0, 8'h30); op(`FWG_OP_READ, 0, 0);
      t = rdata_r[6];
      chk("window", 8'h00, {7'h00, rdata_r[3]});
      op(`FWG_OP_READ, 0, 0); chk("toggle", {7'h00, ~t}, {7'h00, rdata_r[6]});
      op(`FWG_OP_ADD_SECTOR, 19'h10000, 8'h30);
      chk("open add", 8'h00, {7'h00, rejected_r});
      repeat (80) @(posedge mclk);
      op(`FWG_OP_ADD_SECTOR, 19'h20000, 8'h30);
      chk("late add", 8'h01, {7'h00, rejected_r});
      repeat (200) @(posedge mclk);
      op(`FWG_OP_READ, 19'h3, 0); chk("after erase", 8'h00, rdata_r);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    s_program;
    s_protect;
    s_id;
    s_erase;
    conclude();
  end
endmodule
`default_nettype wire
